// file: common/sram_host_pkg.sv
// Package: constants and the request carrier for the static memory host port
package sram_host_pkg;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 4;
   localparam int CLK_PERIOD_PS = 5000;
   // Timing figures as printed (ns), host-side margins for the fastest grade
   localparam int ADDR_ACCESS_NS = 25;
   localparam int SELECT_ACCESS_NS = 25;
   localparam int SELECT_TO_OUTPUT_ON_DELAY_NS = 5;
   localparam int STROBE_TO_OUTPUT_OFF_DELAY_NS = 15;
   localparam int WRITE_PULSE_NS = 20;
   localparam int DATA_SETUP_NS = 10;
   localparam int DATA_HOLD_NS = 3;
   localparam int ADDR_HOLD_NS = 2;
   // Least times round up to whole cycles
   localparam int ACCESS_CYC = (ADDR_ACCESS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int OFF_CYC = (STROBE_TO_OUTPUT_OFF_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int SETUP_CYC = (DATA_SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int PULSE_CYC = (WRITE_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int HOLD_CYC = (DATA_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int SYNC_CYC = 2;
   localparam int CNT_W = 4;
   localparam logic [DATA_W-1:0] DATA_RST = 4'h0;
   localparam logic [ADDR_W-1:0] ADDR_RST = 12'h000;

   typedef struct packed {
      logic              write;
      logic [ADDR_W-1:0] word_address;
      logic [DATA_W-1:0] data;
   } req_s;

   typedef enum logic [2:0] {
      ST_IDLE, ST_RD_WAIT, ST_WR_OFF, ST_WR_DATA, ST_WR_HOLD, ST_DONE
   } state_e;
endpackage

// file: verification/sram_host_checker.sv
// Checker: pin timing relations of the static memory host port
`timescale 1ns/100ps
`default_nettype none
module sram_host_checker (
   input wire logic                              clk_in,
   input wire logic                              rst_b_in,
   input wire logic                              req_valid_in,
   input wire logic                              req_ready_out,
   input wire logic                              rd_valid_out,
   input wire logic                              wr_done_out,
   input wire logic                              select_b_out,
   input wire logic                              strobe_b_out,
   input wire logic                              data_oe_out,
   input wire sram_host_pkg::req_s               req_in,
   input wire logic [sram_host_pkg::ADDR_W-1:0]  word_address_out,
   input wire logic [sram_host_pkg::DATA_W-1:0]  data_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_b_in);
   sequence rd_take_s; req_valid_in && req_ready_out && !req_in.write; endsequence
   sequence wr_take_s; req_valid_in && req_ready_out && req_in.write; endsequence
   sequence rd_walk_s; (!select_b_out && strobe_b_out) [*8] ##1 select_b_out; endsequence
   sequence wr_walk_s; (!select_b_out && !strobe_b_out) [*5] ##1 (select_b_out && strobe_b_out); endsequence
   chk_read_walk: assert property (rd_take_s |=> rd_walk_s) else $error("read pin walk wrong");
   chk_read_answer: assert property (rd_take_s |-> ##9 rd_valid_out) else $error("read answer late");
   chk_write_walk: assert property (wr_take_s |=> wr_walk_s) else $error("write pin walk wrong");
   chk_write_answer: assert property (wr_take_s |-> ##7 wr_done_out) else $error("write answer late");
   chk_bus_turn: assert property ($fell(strobe_b_out) |-> !data_oe_out [*3]) else $error("bus driven early");
   chk_data_setup: assert property ($rose(strobe_b_out) |-> $past(data_oe_out, 2)) else $error("setup short");
   chk_data_hold: assert property ($rose(strobe_b_out) |-> data_oe_out && $stable(data_out)) else $error("hold");
   chk_end_together: assert property ($rose(strobe_b_out) |-> $rose(select_b_out)) else $error("end split");
   chk_addr_steady: assert property (!select_b_out && $past(!select_b_out) |-> $stable(word_address_out))
      else $error("address moved in access");
endmodule // sram_host_checker
bind sram_host_port sram_host_checker sram_host_checker_inst (
   .clk_in           (clk_in),
   .rst_b_in         (rst_b_in),
   .req_valid_in     (req_valid_in),
   .req_ready_out    (req_ready_out),
   .rd_valid_out     (rd_valid_out),
   .wr_done_out      (wr_done_out),
   .select_b_out     (select_b_out),
   .strobe_b_out     (strobe_b_out),
   .data_oe_out      (data_oe_out),
   .req_in           (req_in),
   .word_address_out (word_address_out),
   .data_out         (data_out)
);
`default_nettype wire

// file: verification/sram_host_port_bench.sv
// Bench: random and corner transfers through the host port into the memory model
`timescale 1ns/100ps
`default_nettype none
module sram_host_port_bench;
   logic                             clk_in = 1'b0, rst_b_in = 1'b0, req_valid_in = 1'b0;
   sram_host_pkg::req_s              req_in = '0;
   logic                             req_ready_out, rd_valid_out, wr_done_out, select_b_out, strobe_b_out, data_oe_out;
   logic [sram_host_pkg::DATA_W-1:0] rd_data_out, data_out, data_in;
   logic [sram_host_pkg::ADDR_W-1:0] word_address_out;
   logic [sram_host_pkg::DATA_W-1:0] shadow [0:4095];
   logic [11:0]                      corner [4] = '{12'h000, 12'hFFF, 12'h800, 12'h7FF};
   logic [31:0]                      lfsr = 32'h00010BE1;
   int                               n_errors = 0, compares = 0;
   always #2.5 clk_in = ~clk_in;
   sram_host_port sram_host_port_inst (
      .clk_in           (clk_in),
      .rst_b_in         (rst_b_in),
      .req_in           (req_in),
      .req_valid_in     (req_valid_in),
      .req_ready_out    (req_ready_out),
      .rd_data_out      (rd_data_out),
      .rd_valid_out     (rd_valid_out),
      .wr_done_out      (wr_done_out),
      .select_b_out     (select_b_out),
      .strobe_b_out     (strobe_b_out),
      .word_address_out (word_address_out),
      .data_out         (data_out),
      .data_oe_out      (data_oe_out),
      .data_in          (data_in)
   );
   sram_model sram_model_inst (.select_b_in(select_b_out), .strobe_b_in(strobe_b_out), .addr_in(word_address_out),
                               .host_data_in(data_out), .host_oe_in(data_oe_out), .bus_out(data_in));
   function automatic logic [31:0] next_rand(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [3:0] expect_rd(input logic [11:0] a);
      return shadow[a];
   endfunction
   // Write: off delay, data setup, hold; read: access, launch cycle, synchroniser
   function automatic int expect_lat(input logic w);
      return w ? sram_host_pkg::OFF_CYC + sram_host_pkg::SETUP_CYC + sram_host_pkg::HOLD_CYC
               : sram_host_pkg::ACCESS_CYC + 1 + sram_host_pkg::SYNC_CYC;
   endfunction
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (exp !== got) begin
         n_errors++;
         $display("[ERR] %s expected %0h seen %0h", what, exp, got);
      end
   endtask
   task automatic wrap_up;
      $display("compares %0d n_errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic xfer(input logic w, input logic [11:0] a, input logic [3:0] d);
      int n;
      n = 0;
      while (req_ready_out !== 1'b1 && n < 20) begin @(posedge clk_in); #1; n++; end
      check("select idle", 1, select_b_out);
      req_in = '{write: w, word_address: a, data: d};
      req_valid_in = 1'b1;
      @(posedge clk_in); #1;
      req_valid_in = 1'b0;
      n = 0;
      while ((w ? wr_done_out : rd_valid_out) !== 1'b1 && n < 20) begin @(posedge clk_in); #1; n++; end
      check("answer latency", expect_lat(w), n);
      if (w) shadow[a] = d;
      else check("read word", expect_rd(a), rd_data_out);
   endtask
   // ------------------------------------------------
   // Main sequence
   // ------------------------------------------------
   initial begin
      foreach (shadow[i]) shadow[i] = 4'h0;
      repeat (6) @(posedge clk_in);
      #1 check("select in reset", 1, select_b_out);
      check("drive in reset", 0, data_oe_out);
      rst_b_in = 1'b1;
      // Overwrite then read back at once, at the address extremes and either side of the midpoint
      for (int i = 0; i < 4; i++) begin
         xfer(1'b1, corner[i], ~corner[i][3:0]);
         xfer(1'b1, corner[i], corner[i][3:0]);
         xfer(1'b0, corner[i], 4'h0);
      end
      repeat (250) begin
         lfsr = next_rand(lfsr);
         xfer(lfsr[0], lfsr[13:2] & (lfsr[20] ? 12'hFFF : 12'h00F), lfsr[27:24]);
      end
      wrap_up;
   end
   initial begin
      #(5 * 6000);
      n_errors++;
      wrap_up;
   end
endmodule // sram_host_port_bench
`default_nettype wire

// file: verification/sram_model.sv
// Behavioural model of the 4K x 4 static memory on the far side of the host port
`timescale 1ns/100ps
`default_nettype none
module sram_model (
   input  wire logic        select_b_in,
   input  wire logic        strobe_b_in,
   input  wire logic [11:0] addr_in,
   input  wire logic [3:0]  host_data_in,
   input  wire logic        host_oe_in,
   output logic      [3:0]  bus_out
);
   logic [3:0] mem [0:4095];
   logic [3:0] rd_q;
   logic [3:0] junk = 4'h5;
   logic       drv;
   logic       wr_act = 1'b0;
   initial foreach (mem[i]) mem[i] = 4'h0;
   always #5 junk = ~junk;
   // Stale word shows until the access delay runs out
   assign #25 rd_q = mem[addr_in];
   assign drv = !select_b_in && strobe_b_in;
   // Floating bus toggles between 4'h5 and 4'hA, so a late sample matches by luck only a word of 4'h5 or 4'hA
   assign bus_out = host_oe_in ? (drv ? 4'hX : host_data_in) : (drv ? rd_q : junk);
   always @(select_b_in or strobe_b_in) begin
      // Host side taken directly, so a zero-time glitch of the own drivers is never stored
      if (wr_act) mem[addr_in] = host_oe_in ? host_data_in : 4'hX;
      wr_act = !select_b_in && !strobe_b_in;
   end
endmodule // sram_model
`default_nettype wire

// file: verilog/sram_host_port.sv
// Host controller driving an asynchronous 4K x 4 static memory over its pins
`timescale 1ns/100ps
`default_nettype none
module sram_host_port (
   input  wire logic                                clk_in,
   input  wire logic                                rst_b_in,
   input  wire sram_host_pkg::req_s                 req_in,
   input  wire logic                                req_valid_in,
   output logic                                     req_ready_out,
   output logic [sram_host_pkg::DATA_W-1:0]         rd_data_out,
   output logic                                     rd_valid_out,
   output logic                                     wr_done_out,
   output logic                                     select_b_out,
   output logic                                     strobe_b_out,
   output logic [sram_host_pkg::ADDR_W-1:0]         word_address_out,
   output logic [sram_host_pkg::DATA_W-1:0]         data_out,
   output logic                                     data_oe_out,
   input  wire logic [sram_host_pkg::DATA_W-1:0]    data_in
);
   sram_host_pkg::state_e               state_r;
   logic [sram_host_pkg::CNT_W-1:0]     cnt_r;
   logic [sram_host_pkg::DATA_W-1:0]    sync1_r;
   logic [sram_host_pkg::DATA_W-1:0]    sync2_r;
   logic                                start;
   logic                                rd_end;
   logic                                off_end;
   logic                                data_end;
   logic                                hold_end;

   // ----------------------------------------
   // Phase lengths
   // ----------------------------------------
   // Access runs from the launching edge, so one cycle covers pin skew before the synchroniser
   localparam int RD_CYC   = sram_host_pkg::ACCESS_CYC + 1 + sram_host_pkg::SYNC_CYC;
   // Strobe low must cover both the data setup and the whole write pulse
   localparam int DATA_CYC = (sram_host_pkg::SETUP_CYC > sram_host_pkg::PULSE_CYC - sram_host_pkg::OFF_CYC)
                             ? sram_host_pkg::SETUP_CYC : sram_host_pkg::PULSE_CYC - sram_host_pkg::OFF_CYC;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   // Counter load for a phase of n cycles
   function automatic logic [sram_host_pkg::CNT_W-1:0] cyc(input int n);
      cyc = sram_host_pkg::CNT_W'(n - 1);
   endfunction

   // Last cycle of a counted phase
   function automatic logic phase_end(input sram_host_pkg::state_e        s,
                                      input sram_host_pkg::state_e        now,
                                      input logic [sram_host_pkg::CNT_W-1:0] cnt);
      phase_end = (now == s) && (cnt == '0);
   endfunction

   assign start    = req_valid_in && req_ready_out;
   assign rd_end   = phase_end(sram_host_pkg::ST_RD_WAIT, state_r, cnt_r);
   assign off_end  = phase_end(sram_host_pkg::ST_WR_OFF, state_r, cnt_r);
   assign data_end = phase_end(sram_host_pkg::ST_WR_DATA, state_r, cnt_r);
   assign hold_end = phase_end(sram_host_pkg::ST_WR_HOLD, state_r, cnt_r);

   // ----------------------------------------
   // Pin input synchroniser
   // ----------------------------------------
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         sync1_r <= sram_host_pkg::DATA_RST;
         sync2_r <= sram_host_pkg::DATA_RST;
      end else begin
         sync1_r <= data_in;
         sync2_r <= sync1_r;
      end
   end

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         state_r <= sram_host_pkg::ST_IDLE;
      end else begin
         case (state_r)
            sram_host_pkg::ST_IDLE: begin
               if (start) begin
                  state_r <= req_in.write ? sram_host_pkg::ST_WR_OFF : sram_host_pkg::ST_RD_WAIT;
               end
            end
            sram_host_pkg::ST_RD_WAIT: begin
               if (rd_end) begin
                  state_r <= sram_host_pkg::ST_DONE;
               end
            end
            sram_host_pkg::ST_WR_OFF: begin
               if (off_end) begin
                  state_r <= sram_host_pkg::ST_WR_DATA;
               end
            end
            sram_host_pkg::ST_WR_DATA: begin
               if (data_end) begin
                  state_r <= sram_host_pkg::ST_WR_HOLD;
               end
            end
            sram_host_pkg::ST_WR_HOLD: begin
               if (hold_end) begin
                  state_r <= sram_host_pkg::ST_DONE;
               end
            end
            sram_host_pkg::ST_DONE: begin
               state_r <= sram_host_pkg::ST_IDLE;
            end
            default: begin
               state_r <= sram_host_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------
   // Phase counter
   // ----------------------------------------
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         cnt_r <= '0;
      end else if (start) begin
         cnt_r <= req_in.write ? cyc(sram_host_pkg::OFF_CYC) : cyc(RD_CYC);
      end else if (off_end) begin
         cnt_r <= cyc(DATA_CYC);
      end else if (data_end) begin
         cnt_r <= cyc(sram_host_pkg::HOLD_CYC);
      end else if (cnt_r != '0) begin
         cnt_r <= cnt_r - 1'b1;
      end
   end

   // ----------------------------------------
   // Memory select
   // ----------------------------------------
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         select_b_out <= 1'b1;
      end else if (start) begin
         select_b_out <= 1'b0;
      end else if (rd_end) begin
         select_b_out <= 1'b1; // Deselect for standby between accesses
      end else if (data_end) begin
         select_b_out <= 1'b1; // Rises with the strobe, so memory never re-drives
      end
   end

   // ----------------------------------------
   // Write strobe
   // ----------------------------------------
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         strobe_b_out <= 1'b1;
      end else if (start) begin
         // Falls with select: write begins here, memory stays floating
         strobe_b_out <= !req_in.write;
      end else if (data_end) begin
         strobe_b_out <= 1'b1; // Strobe rise ends write; data held after
      end
   end

   // ----------------------------------------
   // Address and write data
   // ----------------------------------------
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         word_address_out <= sram_host_pkg::ADDR_RST;
         data_out         <= sram_host_pkg::DATA_RST;
      end else if (start) begin
         // Only loaded while both controls are high
         word_address_out <= req_in.word_address;
         data_out         <= req_in.data;
      end
   end

   // ----------------------------------------
   // Bus drive
   // ----------------------------------------
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         data_oe_out <= 1'b0;
      end else if (off_end) begin
         data_oe_out <= 1'b1; // Drive only after output-off delay
      end else if (hold_end) begin
         data_oe_out <= 1'b0;
      end
   end

   // ----------------------------------------
   // Request handshake
   // ----------------------------------------
   // Ready drops on the taking edge, so a second request waits for the answer
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         req_ready_out <= 1'b0;
      end else begin
         req_ready_out <= (state_r == sram_host_pkg::ST_DONE) ||
                          (state_r == sram_host_pkg::ST_IDLE && !start);
      end
   end

   // ----------------------------------------
   // Read answer
   // ----------------------------------------
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rd_data_out  <= sram_host_pkg::DATA_RST;
         rd_valid_out <= 1'b0;
      end else begin
         rd_valid_out <= rd_end;
         if (rd_end) begin
            rd_data_out <= sync2_r; // Word picked by address
         end
      end
   end

   // ----------------------------------------
   // Write answer
   // ----------------------------------------
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         wr_done_out <= 1'b0;
      end else begin
         wr_done_out <= hold_end;
      end
   end
endmodule // sram_host_port
`default_nettype wire
